// File: shared/ccpts_pkg.sv
// Package: register map and encodings for the capture unit timebase selector
package ccpts_pkg;
  localparam int CCPTS_ADDR_W = 4;
  localparam logic [3:0] CCPTS_OFF_SELECT = 4'h0;
  localparam logic [7:0] CCPTS_SELECT_RESET = 8'h00;
  localparam logic [7:0] CCPTS_SELECT_WMASK = 8'hD7;
  localparam int CCPTS_U7_LSB = 6;
  localparam int CCPTS_U6_BIT = 4;
  localparam int CCPTS_U5_BIT = 2;
  localparam int CCPTS_U4_LSB = 0;
  localparam logic [1:0] CCPTS_RESP_OKAY = 2'b00;
  localparam logic [1:0] CCPTS_RESP_SLVERR = 2'b10;
  localparam logic [1:0] CCPTS_U4_RESERVED = 2'b11;
  // Timer identifiers driven on the select outputs
  typedef enum logic [2:0] {
    CCPTS_TIMER_1, CCPTS_TIMER_2, CCPTS_TIMER_3, CCPTS_TIMER_4,
    CCPTS_TIMER_5, CCPTS_TIMER_6, CCPTS_TIMER_8
  } ccpts_timer_t;
endpackage : ccpts_pkg

// File: logic/ccpts_decode.sv
// Decoder: one register field to the capture/compare timer and the PWM timer
`timescale 1ns/10ps
`default_nettype none
module ccpts_decode
  import ccpts_pkg::*;
#(
  parameter int UNIT = 4
) (
  // Field value
  input wire logic [1:0] code,
  // Selected pair
  output var ccpts_timer_t cc_timer,
  output var ccpts_timer_t pwm_timer
);
  always_comb begin
    cc_timer = CCPTS_TIMER_1;
    pwm_timer = CCPTS_TIMER_2;
    case (UNIT)
      7: begin
        if (code != 2'b00) begin
          cc_timer = CCPTS_TIMER_5; // RL1
          case (code)
            2'b01: pwm_timer = CCPTS_TIMER_4;
            2'b10: pwm_timer = CCPTS_TIMER_6;
            default: pwm_timer = CCPTS_TIMER_8;
          endcase
        end
      end
      6: begin
        if (code[0]) begin
          cc_timer = CCPTS_TIMER_5; // RL2
        end
      end
      5: begin
        if (code[0]) begin
          cc_timer = CCPTS_TIMER_5; // RL3
          pwm_timer = CCPTS_TIMER_4;
        end
      end
      default: begin
        // Reserved code falls back to the reset pair rather than an undefined one
        case (code)
          2'b01: begin
            cc_timer = CCPTS_TIMER_3; // RL4
            pwm_timer = CCPTS_TIMER_4;
          end
          2'b10: begin
            cc_timer = CCPTS_TIMER_3; // RL4
            pwm_timer = CCPTS_TIMER_6;
          end
          default: ;
        endcase
      end
    endcase
  end
endmodule : ccpts_decode
`default_nettype wire

// File: logic/ccpts_selector.sv
// Top: AXI4-Lite timebase select register and per-unit timer pair outputs
//
// Behaviour
// RL1: Bits 7..6 choose unit 7's pair: 00 t1/t2, 01 t5/t4, 10 t5/t6, 11 t5/t8.
// RL2: Bit 4 chooses unit 6's pair: 0 t1/t2, 1 t5/t2.
// RL3: Bit 2 chooses unit 5's pair: 0 t1/t2, 1 t5/t4.
// RL4: Bits 1..0 choose unit 4's pair: 00 t1/t2, 01 t3/t4, 10 t3/t6; software never writes 11.
// RL5: Bits 5 and 3 ignore writes and read as zero.
// RL6: The first timer of a pair feeds capture/compare, the second PWM, from the clock after a write.
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
module ccpts_selector
  import ccpts_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [CCPTS_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [CCPTS_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Timer selects, index 0..3 = units 4..7
  output var ccpts_timer_t cc_timer [4],
  output var ccpts_timer_t pwm_timer [4]
);
  logic [7:0] sel_r, sel_nxt;
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_r, bvalid_nxt;
  logic [CCPTS_ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic wstrb0_r, wstrb0_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic aw_hit, w_hit, ar_hit, wr_go;
  logic [CCPTS_ADDR_W-1:0] wa;
  logic [31:0] wd;
  logic ws;

  function automatic logic is_select(input logic [CCPTS_ADDR_W-1:0] a);
    return a == CCPTS_OFF_SELECT;
  endfunction : is_select

  assign awready = !aw_got_r && !bvalid_r;
  assign wready = !w_got_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign aw_hit = awvalid && awready;
  assign w_hit = wvalid && wready;
  assign ar_hit = arvalid && arready;
  assign wa = aw_got_r ? awaddr_r : awaddr;
  assign wd = w_got_r ? wdata_r : wdata;
  assign ws = w_got_r ? wstrb0_r : wstrb[0];
  assign wr_go = (aw_got_r || aw_hit) && (w_got_r || w_hit);

  always_comb begin
    sel_nxt = sel_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb0_nxt = wstrb0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (aw_hit) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = awaddr;
    end
    if (w_hit) begin
      w_got_nxt = 1'b1;
      wdata_nxt = wdata;
      wstrb0_nxt = wstrb[0];
    end
    if (wr_go) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = is_select(wa) ? CCPTS_RESP_OKAY : CCPTS_RESP_SLVERR;
      if (is_select(wa) && ws) begin
        sel_nxt = wd[7:0] & CCPTS_SELECT_WMASK; // RL5
      end
    end else if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (ar_hit) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = is_select(araddr) ? {24'h00_0000, sel_r} : 32'h0000_0000;
      rresp_nxt = is_select(araddr) ? CCPTS_RESP_OKAY : CCPTS_RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_r <= CCPTS_SELECT_RESET;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= CCPTS_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= CCPTS_RESP_OKAY;
    end else begin
      sel_r <= sel_nxt; // RL6
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb0_r <= wstrb0_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // Selects decode straight from the register, so they change one clock after the write
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_unit
      logic [1:0] code;
      if (gi == 3) begin : g_u7
        assign code = sel_r[CCPTS_U7_LSB +: 2]; // RL1
      end else if (gi == 2) begin : g_u6
        assign code = {1'b0, sel_r[CCPTS_U6_BIT]}; // RL2
      end else if (gi == 1) begin : g_u5
        assign code = {1'b0, sel_r[CCPTS_U5_BIT]}; // RL3
      end else begin : g_u4
        assign code = sel_r[CCPTS_U4_LSB +: 2]; // RL4
      end
      ccpts_decode #(.UNIT(gi + 4)) u_dec (
        .code(code),
        .cc_timer(cc_timer[gi]),
        .pwm_timer(pwm_timer[gi])
      ); // RL6
    end
  endgenerate

  // Assertions
  AST_U7_FIELD: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_r[7:6] == 2'b00) == (cc_timer[3] == CCPTS_TIMER_1)) // RL1
    else $error("unit 7 capture timer disagrees with field");
  AST_U7_PWM8: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_r[7:6] == 2'b11) |-> pwm_timer[3] == CCPTS_TIMER_8) // RL1
    else $error("unit 7 code 11 must pick timer 8");
  AST_U6_BIT: assert property (@(posedge aclk) disable iff (!aresetn)
    sel_r[4] |-> cc_timer[2] == CCPTS_TIMER_5 && pwm_timer[2] == CCPTS_TIMER_2) // RL2
    else $error("unit 6 pair wrong");
  AST_U5_BIT: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_r[2] ? pwm_timer[1] == CCPTS_TIMER_4 : pwm_timer[1] == CCPTS_TIMER_2)) // RL3
    else $error("unit 5 pair wrong");
  AST_U4_FIELD: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_r[1:0] == 2'b10) |-> cc_timer[0] == CCPTS_TIMER_3 && pwm_timer[0] == CCPTS_TIMER_6) // RL4
    else $error("unit 4 code 10 pair wrong");
  AST_U4_CODE01: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_r[1:0] == 2'b01) |-> cc_timer[0] == CCPTS_TIMER_3 && pwm_timer[0] == CCPTS_TIMER_4) // RL4
    else $error("unit 4 code 01 pair wrong");
  AST_UNIMPL_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid |-> rdata[5] == 1'b0 && rdata[3] == 1'b0) // RL5
    else $error("unimplemented bits read nonzero");
  sequence s_sel_write;
    wr_go && is_select(wa) && ws;
  endsequence
  AST_WRITE_TAKES: assert property (@(posedge aclk) disable iff (!aresetn)
    s_sel_write ##1 1'b1 |-> sel_r == ($past(wd[7:0]) & CCPTS_SELECT_WMASK)) // RL6
    else $error("select register did not update after write");
  AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    !wr_go |=> $stable(sel_r)) // RL6
    else $error("select register changed without a write");
endmodule : ccpts_selector
`default_nettype wire

// File: tb/ccpts_selector_tb_top.sv
// Testbench: register access and timer pair selection of the timebase selector
`timescale 1ns/10ps
`default_nettype none
module ccpts_selector_tb_top;
  import ccpts_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [CCPTS_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [23:0] sel_snap;
  logic [31:0] rd;
  ccpts_timer_t cc_timer [4];
  ccpts_timer_t pwm_timer [4];
  int mismatches = 0;
  int check_count = 0;
  ccpts_selector u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .cc_timer(cc_timer), .pwm_timer(pwm_timer));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Pair order per unit: capture/compare timer first, PWM timer second
  function automatic logic [23:0] exp_sel(input logic [7:0] v);
    logic [2:0] p7, c4, p4;
    case (v[7:6])
      2'h0: p7 = CCPTS_TIMER_2;
      2'h1: p7 = CCPTS_TIMER_4;
      2'h2: p7 = CCPTS_TIMER_6;
      default: p7 = CCPTS_TIMER_8;
    endcase
    // Reserved unit 4 code falls back to the first pair
    case (v[1:0])
      2'h1: {c4, p4} = {CCPTS_TIMER_3, CCPTS_TIMER_4};
      2'h2: {c4, p4} = {CCPTS_TIMER_3, CCPTS_TIMER_6};
      default: {c4, p4} = {CCPTS_TIMER_1, CCPTS_TIMER_2};
    endcase
    return {(v[7:6] == 2'h0) ? CCPTS_TIMER_1 : CCPTS_TIMER_5, p7,
      v[4] ? CCPTS_TIMER_5 : CCPTS_TIMER_1, CCPTS_TIMER_2,
      v[2] ? CCPTS_TIMER_5 : CCPTS_TIMER_1, v[2] ? CCPTS_TIMER_4 : CCPTS_TIMER_2, c4, p4};
  endfunction : exp_sel
  task automatic axi_write(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    logic aw_go, w_go;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      @(posedge aclk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
      n++;
    end while (!(aw_go && w_go) && !(aw_go && !wvalid) && !(w_go && !awvalid) && n < 40);
    // Selects are sampled in the very cycle the response appears
    @(negedge aclk);
    while (!bvalid && n < 80) begin
      @(negedge aclk);
      n++;
    end
    resp = bresp;
    sel_snap = {cc_timer[3], pwm_timer[3], cc_timer[2], pwm_timer[2],
      cc_timer[1], pwm_timer[1], cc_timer[0], pwm_timer[0]};
    @(posedge aclk);
  endtask : axi_write
  task automatic axi_read(input logic [3:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge aclk); while (!arready && ++n < 40);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid && ++n < 80);
    rd = rdata;
    resp = rresp;
    @(posedge aclk);
  endtask : axi_read
  task automatic test_reset();
    axi_read(CCPTS_OFF_SELECT);
    check(rd, {24'h00_0000, CCPTS_SELECT_RESET});
    check({30'h0000_0000, resp}, {30'h0000_0000, CCPTS_RESP_OKAY});
    check({8'h00, cc_timer[3], pwm_timer[3], cc_timer[2], pwm_timer[2], cc_timer[1],
      pwm_timer[1], cc_timer[0], pwm_timer[0]}, {8'h00, exp_sel(8'h00)});
    $display("test_reset done");
  endtask : test_reset
  task automatic test_fields();
    logic [7:0] vals [5] = '{8'h41, 8'h96, 8'hC0, 8'h04, 8'h00};
    foreach (vals[i]) begin
      axi_write(CCPTS_OFF_SELECT, vals[i], 4'h1);
      check({30'h0000_0000, resp}, {30'h0000_0000, CCPTS_RESP_OKAY});
      check({8'h00, sel_snap}, {8'h00, exp_sel(vals[i])});
      axi_read(CCPTS_OFF_SELECT);
      check(rd, {24'h00_0000, vals[i]});
    end
    $display("test_fields done");
  endtask : test_fields
  task automatic test_unimpl();
    // Unit 4 gets code 10 here: software must not store the reserved code
    axi_write(CCPTS_OFF_SELECT, 8'hFE, 4'h1);
    check({8'h00, sel_snap}, {8'h00, exp_sel(8'hD6)});
    axi_read(CCPTS_OFF_SELECT);
    check(rd, 32'h0000_00D6);
    $display("test_unimpl done");
  endtask : test_unimpl
  task automatic test_refused();
    // Neither an unmapped address nor a masked byte lane may alter the selection
    axi_write(4'h4, 8'h00, 4'h1);
    check({30'h0000_0000, resp}, {30'h0000_0000, CCPTS_RESP_SLVERR});
    axi_write(CCPTS_OFF_SELECT, 8'h00, 4'h0);
    check({8'h00, sel_snap}, {8'h00, exp_sel(8'hD6)});
    axi_read(4'h8);
    check({rd[29:0], resp}, {30'h0000_0000, CCPTS_RESP_SLVERR});
    axi_read(CCPTS_OFF_SELECT);
    check(rd, 32'h0000_00D6);
    $display("test_refused done");
  endtask : test_refused
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (3000) @(posedge aclk);
    mismatches++;
    complete_run();
  end
  initial begin
    {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata, wstrb} = '0;
    bready = 1'b1;
    rready = 1'b1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset();
    test_fields();
    test_unimpl();
    test_refused();
    complete_run();
  end
endmodule : ccpts_selector_tb_top
`default_nettype wire
